// File: design/rac_byte_match.sv
// One alarm byte comparator with a don't-care override
`timescale 1ns/10ps
`default_nettype none
module rac_byte_match #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] cur,   // Current time byte
  input  wire logic [W-1:0] alm,   // Alarm byte
  input  wire logic         dc,    // Byte excluded from comparison
  output logic              match  // Byte matches or is excluded
);
  always_comb
  begin
    match = dc || (cur == alm);
  end
endmodule
`default_nettype wire

// File: design/rac_pkg.sv
// Shared constants and types of the rtc alarm and interrupt control block
package rac_pkg;
  // Control and status register offsets
  localparam logic [7:0] ADDR_RATE  = 8'h0A;
  localparam logic [7:0] ADDR_IEN   = 8'h0B;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_DAY   = 8'h0D;
  // Field positions
  localparam int A_PEND = 7;
  localparam int B_INHIBIT = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int C_IRQ_REQUEST_FLAG = 7;
  localparam int C_PF = 6;
  localparam int C_AF = 5;
  localparam int C_UF = 4;
  localparam int D_VALID = 7;
  // Oscillator control codes and the alarm don't-care code
  localparam logic [2:0] OSC_START = 3'h2;
  localparam logic [2:0] OSC_RUN_ALT = 3'h3;
  localparam logic [1:0] OSC_HOLD_HI = 2'h3;
  localparam logic [1:0] ALM_DC = 2'h3;
  // Reset values of the reset-affected fields
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  // Time base prescaler: 15 bits of 32.768 kHz make one second
  localparam int PRESC_W = 15;
  localparam logic [14:0] PRESC_HALF = 15'h4000;
  localparam logic [3:0] RATE_FAST1 = 4'h1;
  localparam logic [3:0] RATE_FAST2 = 4'h2;
  localparam int FAST1_BITS = 7;
  localparam int FAST2_BITS = 8;
  // Timing, in time base ticks and in ref_clk cycles
  localparam int TB_HZ = 32768;
  localparam int BUC_US = 244;
  localparam int UPD_US = 1984;
  localparam int BUC_TICKS = (BUC_US * TB_HZ + 999999) / 1000000;
  localparam int UPD_TICKS = (UPD_US * TB_HZ + 999999) / 1000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CSR_MS = 200;
  localparam int CSR_CYC = CSR_MS * 1000000 / CLK_PERIOD_NS;
  // Daylight saving calendar values, BCD and binary forms
  localparam logic [7:0] SUNDAY = 8'h01;
  localparam logic [7:0] APRIL = 8'h04;
  localparam logic [7:0] OCT_BCD = 8'h10;
  localparam logic [7:0] OCT_BIN = 8'h0A;
  localparam logic [7:0] WEEK1_END = 8'h07;
  localparam logic [7:0] LASTWK_BCD = 8'h25;
  localparam logic [7:0] LASTWK_BIN = 8'h19;
  localparam logic [7:0] HOUR_ONE = 8'h01;
  localparam logic [7:0] MAX59_BCD = 8'h59;
  localparam logic [7:0] MAX59_BIN = 8'h3B;
  typedef enum logic [1:0] {UPD_IDLE = 2'b00, UPD_LEAD = 2'b01, UPD_BUSY = 2'b10} rac_upd_e;
endpackage

// File: design/rac_sync.sv
// Two-flop synchroniser for a level arriving from outside ref_clk
`timescale 1ns/10ps
`default_nettype none
module rac_sync (
  input  wire logic ref_clk, // System clock
  input  wire logic rst,     // Asynchronous reset
  input  wire logic din,     // Asynchronous level
  output logic      dout     // Synchronised level
);
  logic meta_r;
  logic meta_nxt;
  logic dout_nxt;
  always_comb
  begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule
`default_nettype wire

// File: design/rac_top.sv
// Operation
// - Periodic enable raises a request once per selected rate period.
// - Each update compares day, hour, minute, second with alarms; all match sets alarm flag.
// - Alarm request only when alarm enable set; flag sets regardless.
// - Second, minute or hour alarm with top two bits 11 matches anything.
// - Day alarm field zero removes day from the comparison.
// - Alarm detection and request keep working on the backup cell.
// - Update end sets update flag; request needs update enable and no inhibit.
// - Update pending reading 0 with inhibit clear guarantees lead time before the next update.
// - Oscillator codes: 010/011 run all, 11X hold divider, others stop.
// - Writing 010 makes the first update happen 500 ms later.
// - Power fail blocks host writes, and for the recovery time after.
// - Control registers are readable at any time and writable outside power fail protection, even during updates.
// - Registers at 0A-0D; third read-only; write masks on first and fourth.
// - Reset clears enables, bit 3 and flags; other fields unaffected.
// - Update pending rises before each update, clears at end, low under inhibit.
// - Daylight saving: October fall back at 1:59:59, April skip 2 to 3.
// - Hour format bit: 1 is 24-hour, 0 is 12-hour.
// - Number format bit: 1 is binary, 0 is BCD.
// - Transfer inhibit forces the update enable to 0.
// - Transfer inhibit stops the copy into the host buffer.
// - Reading the flag register clears all flags and releases the request pin.
// - Summary flag set when any flag and its enable are both 1.
// - Rate 0 off; 1,2 are 3.9 and 7.8 ms; 3-15 double from 122 us.
`timescale 1ns/10ps
`default_nettype none
module rac_top
  import rac_pkg::*;
#(
  parameter int RECOVER_CYC = CSR_CYC
) (
  input  wire logic       ref_clk,        // 200 MHz clock
  input  wire logic       rst,            // Block reset
  input  wire logic       por,            // Power-on reset of all state
  input  wire logic       osc_32k,        // Crystal time base, asynchronous
  input  wire logic       pwr_fail,       // Supply below threshold, asynchronous
  input  wire logic       backup_ok,      // Backup energy valid, asynchronous
  input  wire logic       ext_storage_sel,// High selects extended storage
  input  wire logic [7:0] reg_addr,       // Register address
  input  wire logic [7:0] reg_wdata,      // Write data
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  output logic      [7:0] reg_rdata,      // Read data
  input  wire logic [7:0] cur_sec,        // Current seconds
  input  wire logic [7:0] cur_min,        // Current minutes
  input  wire logic [7:0] cur_hour,       // Current hours
  input  wire logic [7:0] cur_wday,       // Current day of week
  input  wire logic [7:0] cur_mday,       // Current day of month
  input  wire logic [7:0] cur_month,      // Current month
  input  wire logic [7:0] alm_sec,        // Seconds alarm byte
  input  wire logic [7:0] alm_min,        // Minutes alarm byte
  input  wire logic [7:0] alm_hour,       // Hours alarm byte
  output logic            update_start,   // Calendar advance pulse
  output logic            copy_strobe,    // Copy time into host buffer
  output logic            dst_fall,       // Repeat the 1 AM hour
  output logic            dst_spring,     // Advance to 3 AM instead of 2 AM
  output logic            osc_run,        // Oscillator enabled
  output logic            div_run,        // Divider enabled
  output logic            hour_format,    // 1 = 24-hour
  output logic            number_format,  // 1 = binary
  output logic            write_protect,  // Storage writes blocked
  output logic            irq_out,        // Request pin output value
  output logic            irq_oe          // Request pin drive enable
);
  logic       osc_s;
  logic       pfail_s;
  logic       valid_s;
  logic       osc_d_r, osc_d_nxt;
  logic [6:0] rate_osc_r, rate_osc_nxt;
  logic [2:0] osc_ctrl;
  logic [3:0] periodic_rate_sel;
  logic       transfer_inhibit_r, transfer_inhibit_nxt;
  logic [3:0] ien_r, ien_nxt;
  logic       number_format_r, number_format_nxt;
  logic       hour_format_r, hour_format_nxt;
  logic       dse_r, dse_nxt;
  logic [5:0] day_alarm_field_r, day_alarm_field_nxt;
  logic       periodic_flag_r, periodic_flag_nxt;
  logic       alarm_flag_r, alarm_flag_nxt;
  logic       update_done_flag_r, update_done_flag_nxt;
  logic       irq_request_flag_r, irq_request_flag_nxt;
  logic [PRESC_W-1:0] presc_r, presc_nxt;
  rac_upd_e   upd_st_r, upd_st_nxt;
  logic [6:0] upd_cnt_r, upd_cnt_nxt;
  logic       fallen_r, fallen_nxt;
  logic [31:0] recov_r, recov_nxt;
  logic [7:0] rdata_nxt;
  logic       tick, per_evt, upd_end, rd_flags, wr_ok, alarm_hit, at_wrap;
  logic       m_sec, m_min, m_hour, m_day;
  logic [PRESC_W-1:0] rate_mask;
  logic       periodic_irq_en, alarm_irq_en, update_irq_en;
  logic       update_pending;
  logic       is_sun, t_0159, oct_last, apr_first;

  rac_sync u_sync_osc (.ref_clk(ref_clk), .rst(por), .din(osc_32k), .dout(osc_s));
  rac_sync u_sync_pf (.ref_clk(ref_clk), .rst(por), .din(pwr_fail), .dout(pfail_s));
  rac_sync u_sync_vb (.ref_clk(ref_clk), .rst(por), .din(backup_ok), .dout(valid_s));

  assign osc_ctrl = rate_osc_r[6:4];
  assign periodic_rate_sel = rate_osc_r[3:0];
  assign periodic_irq_en = ien_r[3];
  assign alarm_irq_en = ien_r[2];
  assign update_irq_en = ien_r[1];

  always_comb
  begin
    div_run = (osc_ctrl == OSC_START) || (osc_ctrl == OSC_RUN_ALT);
    osc_run = div_run || (osc_ctrl[2:1] == OSC_HOLD_HI);
  end

  always_comb
  begin
    case (periodic_rate_sel)
      RATE_FAST1: rate_mask = PRESC_W'((1 << FAST1_BITS) - 1);
      RATE_FAST2: rate_mask = PRESC_W'((1 << FAST2_BITS) - 1);
      default:    rate_mask = PRESC_W'((1 << (32'(periodic_rate_sel) - 1)) - 1);
    endcase
  end

  // Alarm comparators; hour bit 7 (PM) takes part in the compare
  // top-two-bits don't care
  rac_byte_match #(.W(8)) u_m_sec (.cur(cur_sec), .alm(alm_sec), .dc(alm_sec[7:6] == ALM_DC), .match(m_sec));
  rac_byte_match #(.W(8)) u_m_min (.cur(cur_min), .alm(alm_min), .dc(alm_min[7:6] == ALM_DC), .match(m_min));
  rac_byte_match #(.W(8)) u_m_hr (.cur(cur_hour), .alm(alm_hour), .dc(alm_hour[7:6] == ALM_DC),
                                  .match(m_hour));
  rac_byte_match #(.W(6)) u_m_day (.cur(cur_mday[5:0]), .alm(day_alarm_field_r),
                                   .dc(day_alarm_field_r == 6'h00), .match(m_day));

  // Daylight saving windows, evaluated in the selected number format
  always_comb
  begin
    is_sun = (cur_wday == SUNDAY);
    t_0159 = (cur_hour == HOUR_ONE) && (cur_min == (number_format_r ? MAX59_BIN : MAX59_BCD))
             && (cur_sec == (number_format_r ? MAX59_BIN : MAX59_BCD));
    oct_last = is_sun && (cur_month == (number_format_r ? OCT_BIN : OCT_BCD))
               && (cur_mday >= (number_format_r ? LASTWK_BIN : LASTWK_BCD));
    apr_first = is_sun && (cur_month == APRIL) && (cur_mday <= WEEK1_END);
  end

  // Time base, update sequencing and daylight saving state
  always_comb
  begin
    osc_d_nxt = osc_s;
    tick = osc_run && osc_s && !osc_d_r;
    at_wrap = tick && div_run && (presc_r == '1);
    presc_nxt = presc_r;
    upd_st_nxt = upd_st_r;
    upd_cnt_nxt = upd_cnt_r;
    upd_end = 1'b0;
    update_start = 1'b0;
    fallen_nxt = fallen_r;
    if (!div_run)
      presc_nxt = '0;
    else if (tick)
      presc_nxt = presc_r + 1'b1;
    // first update half a second on
    if (wr_ok && reg_addr == ADDR_RATE && reg_wdata[6:4] == OSC_START)
      presc_nxt = PRESC_HALF;
    case (upd_st_r)
      UPD_IDLE:
      begin
        if (tick && div_run && presc_r == PRESC_W'(2 ** PRESC_W - 1 - BUC_TICKS))
          upd_st_nxt = UPD_LEAD;
      end
      UPD_LEAD:
      begin
        if (at_wrap)
        begin
          upd_st_nxt = UPD_BUSY;
          upd_cnt_nxt = 7'(UPD_TICKS);
          update_start = 1'b1;
        end
      end
      UPD_BUSY:
      begin
        if (tick)
        begin
          upd_cnt_nxt = upd_cnt_r - 1'b1;
          if (upd_cnt_r == 7'h01)
          begin
            upd_st_nxt = UPD_IDLE;
            upd_end = 1'b1;
          end
        end
      end
      default: upd_st_nxt = UPD_IDLE;
    endcase
    dst_fall = update_start && dse_r && oct_last && t_0159 && !fallen_r;
    dst_spring = update_start && dse_r && apr_first && t_0159;
    if (dst_fall)
      fallen_nxt = 1'b1;
    else if (!oct_last)
      fallen_nxt = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge por)
  begin
    if (por)
    begin
      osc_d_r <= 1'b0;
      presc_r <= '0;
      upd_st_r <= UPD_IDLE;
      upd_cnt_r <= 7'h00;
      fallen_r <= 1'b0;
    end
    else
    begin
      osc_d_r <= osc_d_nxt;
      presc_r <= presc_nxt;
      upd_st_r <= upd_st_nxt;
      upd_cnt_r <= upd_cnt_nxt;
      fallen_r <= fallen_nxt;
    end
  end

  assign update_pending = (upd_st_r != UPD_IDLE) && !transfer_inhibit_r;
  assign copy_strobe = upd_end && !transfer_inhibit_r;
  assign hour_format = hour_format_r;
  assign number_format = number_format_r;

  // Power fail protection with recovery hold
  always_comb
  begin
    if (pfail_s)
      recov_nxt = 32'(RECOVER_CYC);
    else if (recov_r != 32'h0)
      recov_nxt = recov_r - 1'b1;
    else
      recov_nxt = recov_r;
    write_protect = pfail_s || (recov_r != 32'h0);
    wr_ok = reg_wr && !ext_storage_sel && !write_protect;
    rd_flags = reg_rd && !ext_storage_sel && reg_addr == ADDR_FLAGS;
  end

  // Register file and event flags
  always_comb
  begin
    rate_osc_nxt = rate_osc_r;
    transfer_inhibit_nxt = transfer_inhibit_r;
    ien_nxt = ien_r;
    number_format_nxt = number_format_r;
    hour_format_nxt = hour_format_r;
    dse_nxt = dse_r;
    day_alarm_field_nxt = day_alarm_field_r;
    if (wr_ok)
    begin
      case (reg_addr)
        ADDR_RATE: rate_osc_nxt = reg_wdata[6:0];
        ADDR_IEN:
        begin
          transfer_inhibit_nxt = reg_wdata[B_INHIBIT];
          ien_nxt = reg_wdata[B_PIE:3];
          number_format_nxt = reg_wdata[2];
          hour_format_nxt = reg_wdata[1];
          dse_nxt = reg_wdata[0];
        end
        ADDR_DAY: day_alarm_field_nxt = reg_wdata[5:0];
        default: ;
      endcase
    end
    if (transfer_inhibit_nxt)
      ien_nxt[1] = 1'b0;
    // alarm path has no power gating
    alarm_hit = upd_end && m_sec && m_min && m_hour && m_day;
    per_evt = tick && div_run && periodic_rate_sel != 4'h0 && ((presc_r & rate_mask) == rate_mask);
    periodic_flag_nxt = per_evt || (periodic_flag_r && !rd_flags);
    alarm_flag_nxt = alarm_hit || (alarm_flag_r && !rd_flags);
    update_done_flag_nxt = upd_end || (update_done_flag_r && !rd_flags);
    irq_request_flag_nxt = (periodic_flag_nxt && ien_nxt[3]) || (alarm_flag_nxt && ien_nxt[2])
                           || (update_done_flag_nxt && ien_nxt[1] && !transfer_inhibit_nxt)
                           || (irq_request_flag_r && !rd_flags);
    case (reg_addr)
      ADDR_RATE:  rdata_nxt = {update_pending, rate_osc_r};
      ADDR_IEN:   rdata_nxt = {transfer_inhibit_r, ien_r, number_format_r, hour_format_r, dse_r};
      ADDR_FLAGS: rdata_nxt = {irq_request_flag_r, periodic_flag_r, alarm_flag_r, update_done_flag_r, 4'h0};
      ADDR_DAY:   rdata_nxt = {valid_s, 1'b0, day_alarm_field_r};
      default:    rdata_nxt = 8'h00;
    endcase
  end

  // Fields that reset leaves alone only see the power-on reset
  always_ff @(posedge ref_clk or posedge por)
  begin
    if (por)
    begin
      rate_osc_r <= 7'h00;
      transfer_inhibit_r <= 1'b0;
      number_format_r <= 1'b0;
      hour_format_r <= 1'b0;
      dse_r <= 1'b0;
      day_alarm_field_r <= 6'h00;
      recov_r <= 32'h0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      rate_osc_r <= rate_osc_nxt;
      transfer_inhibit_r <= transfer_inhibit_nxt;
      number_format_r <= number_format_nxt;
      hour_format_r <= hour_format_nxt;
      dse_r <= dse_nxt;
      day_alarm_field_r <= day_alarm_field_nxt;
      recov_r <= recov_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst or posedge por)
  begin
    if (rst || por)
    begin
      ien_r <= IEN_RST;
      {periodic_flag_r, alarm_flag_r, update_done_flag_r, irq_request_flag_r} <= FLAGS_RST;
    end
    else
    begin
      ien_r <= ien_nxt;
      periodic_flag_r <= periodic_flag_nxt;
      alarm_flag_r <= alarm_flag_nxt;
      update_done_flag_r <= update_done_flag_nxt;
      irq_request_flag_r <= irq_request_flag_nxt;
    end
  end

  assign irq_out = 1'b0;
  assign irq_oe = irq_request_flag_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || por);

  rd_clear_a: assert property (rd_flags && !per_evt && !upd_end |=> !irq_oe && !periodic_flag_r)
    else $error("flag read did not clear");
  summary_a: assert property ((alarm_flag_r && alarm_irq_en) || (periodic_flag_r && periodic_irq_en)
    |-> irq_oe)
    else $error("enabled flag without request");
  uie_force_a: assert property (transfer_inhibit_r |-> !update_irq_en)
    else $error("update enable set under inhibit");
  pend_mask_a: assert property (transfer_inhibit_r |-> !update_pending)
    else $error("pending shown under inhibit");
  uf_set_a: assert property (upd_end |=> update_done_flag_r && !update_pending)
    else $error("update end missing flag");
  alarm_set_a: assert property (upd_end && m_sec && m_min && m_hour && m_day |=> alarm_flag_r)
    else $error("alarm match lost");
  per_set_a: assert property (per_evt |=> periodic_flag_r)
    else $error("periodic event lost");
  start_half_a: assert property (wr_ok && reg_addr == ADDR_RATE && reg_wdata[6:4] == OSC_START
    |=> presc_r == PRESC_HALF)
    else $error("start code did not load half second");
  protect_a: assert property ($fell(pfail_s) |-> write_protect [*8])
    else $error("protection dropped early");
  lead_a: assert property (update_start |-> $past(upd_st_r) == UPD_LEAD)
    else $error("update without lead");
  cov_irq_c: cover property ($rose(irq_oe));
  cov_alarm_c: cover property (alarm_hit);
  cov_clear_c: cover property (rd_flags && irq_oe);
endmodule
`default_nettype wire

// File: verif/rac_host_model.sv
// Host processor model driving the register strobes of the block
`timescale 1ns/10ps
`default_nettype none
module rac_host_model (
  input  wire logic       ref_clk,   // System clock
  output logic      [7:0] reg_addr,  // Register address
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    // Old data is not left on the bus once the strobe is gone
    reg_wdata = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    d        = reg_rdata;
    reg_rd   = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/rtc_alarm_interrupt_control_tb.sv
// Self-checking bench for the rtc alarm and interrupt control block
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_interrupt_control_tb import rac_pkg::*;;
  // Time base runs far above 32 kHz so periodic events fit the run
  localparam int TICK_CYC = 2;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rac_row_s;
  logic       ref_clk = 1'b0;
  logic       rst, por, osc_32k, pwr_fail, ext_storage_sel, reg_wr, reg_rd;
  logic       osc_run, div_run, hour_format, number_format, write_protect, irq_out, irq_oe;
  logic [7:0] tod, alm_b, rd_v, reg_addr, reg_wdata, reg_rdata;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         tdiv = 0;
  int         t0, t1;
  int         rate_tk [4] = '{128, 256, 4, 8};
  rac_row_s   rows [9] = '{'{ADDR_RATE, 8'h70, 8'h70}, '{ADDR_RATE, 8'hFF, 8'h7F}, '{ADDR_RATE, 8'h60, 8'h60},
                          '{ADDR_IEN, 8'h97, 8'h87}, '{ADDR_IEN, 8'h1E, 8'h1E}, '{ADDR_FLAGS, 8'hFF, 8'h00},
                          '{ADDR_DAY, 8'hFF, 8'hBF}, '{ADDR_DAY, 8'h15, 8'h95}, '{8'h0E, 8'h55, 8'h00}};
  rac_top #(.RECOVER_CYC(16)) rac_top_inst (
    .ref_clk(ref_clk), .rst(rst), .por(por), .osc_32k(osc_32k), .pwr_fail(pwr_fail), .backup_ok(1'b1),
    .ext_storage_sel(ext_storage_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cur_sec(tod), .cur_min(tod), .cur_hour(tod), .cur_wday(tod),
    .cur_mday(tod), .cur_month(tod), .alm_sec(alm_b), .alm_min(alm_b), .alm_hour(alm_b), .update_start(),
    .copy_strobe(), .dst_fall(), .dst_spring(), .osc_run(osc_run), .div_run(div_run),
    .hour_format(hour_format), .number_format(number_format), .write_protect(write_protect),
    .irq_out(irq_out), .irq_oe(irq_oe));
  rac_host_model rac_host_model_inst (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
  begin
    cyc  = cyc + 1;
    tdiv = (tdiv + 1) % (TICK_CYC / 2);
    if (tdiv == 0)
      osc_32k = ~osc_32k;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (irq_oe !== 1'b1 && n < 4000)
    begin
      @(negedge ref_clk);
      n++;
    end
    t = cyc;
    check({6'h00, irq_out, irq_oe}, 8'h01);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rac_host_model_inst.rd_reg(a, rd_v);
    check(rd_v, e);
  endtask
  initial
  begin
    #300000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    osc_32k         = 1'b0;
    pwr_fail        = 1'b0;
    ext_storage_sel = 1'b0;
    tod             = 8'h01;
    alm_b           = 8'hC0;
    rst             = 1'b1;
    por             = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    por = 1'b0;
    repeat (3) @(negedge ref_clk);
    rd_chk(ADDR_IEN, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00);
    foreach (rows[i])
    begin
      rac_host_model_inst.wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    check({6'h00, hour_format, number_format}, 8'h03);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    rd_chk(ADDR_IEN, 8'h06);
    rd_chk(ADDR_DAY, 8'h95);
    rd_chk(ADDR_RATE, 8'h60);
    for (int c = 0; c < 8; c++)
    begin
      rac_host_model_inst.wr_reg(ADDR_RATE, {1'b0, c[2:0], 4'h0});
      check({6'h00, osc_run, div_run}, {6'h00, c inside {2, 3, 6, 7}, c inside {2, 3}});
    end
    pwr_fail = 1'b1;
    repeat (4) @(negedge ref_clk);
    rac_host_model_inst.wr_reg(ADDR_IEN, 8'h40);
    pwr_fail = 1'b0;
    repeat (6) @(negedge ref_clk);
    check({7'h00, write_protect}, 8'h01);
    rac_host_model_inst.wr_reg(ADDR_IEN, 8'h40);
    rd_chk(ADDR_IEN, 8'h06);
    repeat (30) @(negedge ref_clk);
    check({7'h00, write_protect}, 8'h00);
    ext_storage_sel = 1'b1;
    rac_host_model_inst.wr_reg(ADDR_IEN, 8'h40);
    ext_storage_sel = 1'b0;
    rd_chk(ADDR_IEN, 8'h06);
    rac_host_model_inst.wr_reg(ADDR_IEN, 8'h40);
    foreach (rate_tk[i])
    begin
      rac_host_model_inst.wr_reg(ADDR_RATE, {4'h2, 4'(i + 1)});
      rac_host_model_inst.rd_reg(ADDR_FLAGS, rd_v);
      wait_irq(t0);
      rd_chk(ADDR_FLAGS, 8'hC0);
      check({7'h00, irq_oe}, 8'h00);
      wait_irq(t1);
      check({7'h00, (t1 - t0 >= rate_tk[i] * TICK_CYC - 8) && (t1 - t0 <= rate_tk[i] * TICK_CYC + 8)}, 8'h01);
    end
    rac_host_model_inst.wr_reg(ADDR_RATE, 8'h20);
    rac_host_model_inst.rd_reg(ADDR_FLAGS, rd_v);
    repeat (600) @(negedge ref_clk);
    rd_chk(ADDR_FLAGS, 8'h00);
    rac_host_model_inst.wr_reg(ADDR_RATE, 8'h23);
    rac_host_model_inst.wr_reg(ADDR_IEN, 8'h00);
    rac_host_model_inst.rd_reg(ADDR_FLAGS, rd_v);
    repeat (100) @(negedge ref_clk);
    check({7'h00, irq_oe}, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h40);
    // Full update cycle: every alarm byte excluded, so the alarm fires on the first update
    rac_host_model_inst.wr_reg(ADDR_DAY, 8'h00);
    rac_host_model_inst.wr_reg(ADDR_IEN, 8'h30);
    rac_host_model_inst.wr_reg(ADDR_RATE, 8'h20);
    t0 = cyc;
    rac_host_model_inst.rd_reg(ADDR_FLAGS, rd_v);
    repeat (34000)
      if (irq_oe !== 1'b1)
        @(negedge ref_clk);
    check({7'h00, irq_oe}, 8'h01);
    check({7'h00, (cyc - t0 >= 32884) && (cyc - t0 <= 32916)}, 8'h01);
    rd_chk(ADDR_FLAGS, 8'hB0);
    rd_chk(ADDR_RATE, 8'h20);
    final_report;
  end
endmodule
`default_nettype wire
